// ===== src/peq_top.sv
// Touch-probe edge qualifier with direction tracking and APB registers
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns

module peq_top
  import peq_pkg::*;
#(
  parameter int unsigned MS_CYCLES = TICK_CYCLES
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  probe_in,
  input  wire logic [31:0] enc_count,
  output logic [1:0]       hit_pulse,
  output logic             dir_valid,
  output logic             dir_pos,
  output logic [31:0]      true_pos,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  // Settings first, then timers and tracking state
  logic [1:0]         ctrl;
  peq_cfg_t           cfg [2];
  logic [15:0]        dir_thr;
  logic [15:0]        tip_dia;
  logic [IRQ_W-1:0]   irq_stat;
  logic [IRQ_W-1:0]   irq_mask;
  logic [31:0]        hit_pos [2];
  logic [31:0]        tick_cnt;
  logic               ms_tick;
  peq_dir_t           dir;
  peq_dir_t           cand;
  logic [15:0]        acc;
  logic [31:0]        prev_count;
  logic               reversal;
  logic [1:0]         chan_hit;
  logic [1:0]         chan_level;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Read data mux and unmapped detect
  // Unmapped offsets answer with pslverr and change nothing
  // Read-only words ignore writes and answer without error
  function automatic logic known_addr(input logic [7:0] a);
    known_addr = a == OFS_CTRL     ||
                 a == OFS_PCFG0    ||
                 a == OFS_PTIME0   ||
                 a == OFS_PCFG1    ||
                 a == OFS_PTIME1   ||
                 a == OFS_DIRTHR   ||
                 a == OFS_TIPDIA   ||
                 a == OFS_STATE    ||
                 a == OFS_IRQ_STAT ||
                 a == OFS_IRQ_MASK ||
                 a == OFS_HITPOS0  ||
                 a == OFS_HITPOS1  ||
                 a == OFS_TRUEPOS;
  endfunction

  wire        setup_ph = psel && !penable;
  wire        wr_done  = psel && penable && pready && pwrite && !pslverr;
  wire        wr_ctrl  = wr_done && paddr == OFS_CTRL;
  wire        wr_dthr  = wr_done && paddr == OFS_DIRTHR;
  wire        wr_tdia  = wr_done && paddr == OFS_TIPDIA;
  wire        wr_istat = wr_done && paddr == OFS_IRQ_STAT;
  wire        wr_imask = wr_done && paddr == OFS_IRQ_MASK;
  wire [31:0] state_word = {28'h0000000, chan_level, dir_pos, dir_valid};
  // Read word selected by offset; unmapped reads give zero
  wire [31:0] rd_word =
    paddr == OFS_CTRL     ? {30'h00000000, ctrl} :
    paddr == OFS_PCFG0    ? {30'h00000000, cfg[0].edge_sel} :
    paddr == OFS_PTIME0   ? {cfg[0].holdoff_ms, cfg[0].debounce_ms} :
    paddr == OFS_PCFG1    ? {30'h00000000, cfg[1].edge_sel} :
    paddr == OFS_PTIME1   ? {cfg[1].holdoff_ms, cfg[1].debounce_ms} :
    paddr == OFS_DIRTHR   ? {16'h0000, dir_thr} :
    paddr == OFS_TIPDIA   ? {16'h0000, tip_dia} :
    paddr == OFS_STATE    ? state_word :
    paddr == OFS_IRQ_STAT ? {29'h00000000, irq_stat} :
    paddr == OFS_IRQ_MASK ? {29'h00000000, irq_mask} :
    paddr == OFS_HITPOS0  ? hit_pos[0] :
    paddr == OFS_HITPOS1  ? hit_pos[1] :
    paddr == OFS_TRUEPOS  ? true_pos : 32'h00000000;

  // Answer in the cycle after setup, no wait states
  // Read data is zero outside a read access, so a stale word
  // never shows on the bus between transfers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph && !known_addr(paddr);
      prdata  <= (setup_ph && !pwrite) ? rd_word : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Global control, threshold, tip diameter, mask
  // Threshold guidance is left to software; any value is taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl     <= CTRL_RST;
      dir_thr  <= DIRTHR_RST;
      tip_dia  <= TIPDIA_RST;
      irq_mask <= '0;
    end else begin
      if (wr_ctrl) ctrl <= pwdata[1:0];
      if (wr_dthr) dir_thr <= pwdata[15:0];
      if (wr_tdia) tip_dia <= pwdata[15:0];
      if (wr_imask) irq_mask <= pwdata[IRQ_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Millisecond tick
  // ----------------------------------------------------------------
  // One-cycle pulse every MS_CYCLES clocks, shared by all timers
  // Timers in both channels step only on this pulse
  // tick from system clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 32'h00000000;
      ms_tick  <= 1'b0;
    end else if (tick_cnt >= 32'(MS_CYCLES - 1)) begin
      tick_cnt <= 32'h00000000;
      ms_tick  <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h00000001;
      ms_tick  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Probe channels
  // ----------------------------------------------------------------
  // Channel 1 follows the dual bit; when off it still tracks its level
  // two identical qualifiers
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_chan
      wire [7:0] cfg_ofs  = gi == 0 ? OFS_PCFG0 : OFS_PCFG1;
      wire [7:0] time_ofs = gi == 0 ? OFS_PTIME0 : OFS_PTIME1;
      // Second probe only gives hits in dual mode
      wire       chan_on  = gi == 0 || ctrl[CTRL_DUAL_BIT];
      peq_cfg_t  eff_cfg;
      // Write strobes for this channel's two words
      wire       wr_cfg   = wr_done && paddr == cfg_ofs;
      wire       wr_time  = wr_done && paddr == time_ofs;

      always_comb begin
        eff_cfg = cfg[gi];
        if (!chan_on) eff_cfg.edge_sel = EDGE_OFF;
      end

      // Per-channel settings
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cfg[gi] <= CFG_RST;
        end else begin
          if (wr_cfg) cfg[gi].edge_sel <= pwdata[1:0];
          if (wr_time) begin
            cfg[gi].debounce_ms <= pwdata[15:0];
            cfg[gi].holdoff_ms  <= pwdata[31:16];
          end
        end
      end

      peq_chan u_chan (
        .pclk      (pclk),
        .presetn   (presetn),
        .ms_tick   (ms_tick),
        .cfg       (eff_cfg),
        .probe_raw (probe_in[gi]),
        .hit       (chan_hit[gi]),
        .level     (chan_level[gi])
      );

      // Latch compensated position at each hit
      // Position is the compensated one of the cycle before the pulse
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          hit_pos[gi] <= 32'h00000000;
        end else if (chan_hit[gi]) begin
          hit_pos[gi] <= true_pos;
        end
      end
    end
  endgenerate

  // Hit pulses leave straight from the channel flip-flops
  assign hit_pulse = chan_hit;

  // ----------------------------------------------------------------
  // Direction tracking
  // ----------------------------------------------------------------
  // Signed step and its magnitude, clamped to the accumulator width
  // A large jump saturates rather than wraps, so it still confirms
  // Steps in the confirmed direction empty the accumulator,
  // so vibration never adds up to a false reversal
  // A change of candidate starts the count again from the new step
  wire        active   = ctrl[CTRL_ACTIVE_BIT];
  wire [31:0] delta    = enc_count - prev_count;
  wire        moving   = active && delta != 32'h00000000;
  wire        step_neg = delta[31];
  wire [31:0] mag32    = step_neg ? (~delta + 32'h00000001) : delta;
  wire [15:0] mag      = |mag32[31:16] ? 16'hffff : mag32[15:0];
  wire        step_dir_pos = !step_neg;
  wire        with_conf = (dir == DIR_POS && step_dir_pos) || (dir == DIR_NEG && !step_dir_pos);
  wire        same_cand = (cand == DIR_POS) == step_dir_pos && cand != DIR_NONE;
  wire [16:0] acc_sum  = {1'b0, same_cand ? acc : 16'h0000} + {1'b0, mag};
  wire [15:0] next_acc = acc_sum[16] ? 16'hffff : acc_sum[15:0];
  wire        confirm  = moving && !with_conf && next_acc >= dir_thr;

  // Previous encoder sample
  // Sampled every cycle, active or not, so enabling starts clean
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_count <= 32'h00000000;
    end else begin
      prev_count <= enc_count;
    end
  end

  // Inactive: direction kept, candidate and count dropped
  // First confirm from no direction raises no reversal event
  // track sign of motion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir      <= DIR_NONE;
      cand     <= DIR_NONE;
      acc      <= 16'h0000;
      reversal <= 1'b0;
    end else begin
      reversal <= 1'b0;
      if (!active) begin
        cand <= DIR_NONE;
        acc  <= 16'h0000;
      end else if (moving && with_conf) begin
        cand <= DIR_NONE;
        acc  <= 16'h0000;
      end else if (confirm) begin
        dir      <= step_dir_pos ? DIR_POS : DIR_NEG;
        cand     <= DIR_NONE;
        acc      <= 16'h0000;
        reversal <= dir != DIR_NONE;
      end else if (moving) begin
        cand <= step_dir_pos ? DIR_POS : DIR_NEG;
        acc  <= next_acc;
      end
    end
  end

  // Direction outputs
  // Registered copies of the confirmed direction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_valid <= 1'b0;
      dir_pos   <= 1'b0;
    end else begin
      dir_valid <= dir != DIR_NONE;
      dir_pos   <= dir == DIR_POS;
    end
  end

  // ----------------------------------------------------------------
  // Tip compensation
  // ----------------------------------------------------------------
  // Odd diameters lose the half count
  // radius is half the diameter
  wire [31:0] radius = {17'h00000, tip_dia[15:1]};
  // No direction yet: position passes through unchanged
  // offset towards the leading side
  wire [31:0] next_true_pos =
    dir == DIR_POS ? enc_count + radius :
    dir == DIR_NEG ? enc_count - radius : enc_count;

  // Registered compensated position
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      true_pos <= 32'h00000000;
    end else begin
      true_pos <= next_true_pos;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // Sticky events, set wins over write-one clear
  wire [IRQ_W-1:0] irq_set = {reversal, chan_hit};
  wire [IRQ_W-1:0] irq_clr = wr_istat ? pwdata[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] next_stat = (irq_stat & ~irq_clr) | irq_set;
  // Level request from the status after this edge
  wire             next_irq  = |(next_stat & irq_mask);

  // Status bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= next_stat;
    end
  end

  // Interrupt line straight from a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

endmodule

// ===== include/peq_pkg.sv
// Package for the probe edge qualifier: register map, fields and carriers
package peq_pkg;

  // ----------------------------------------------------------------
  // Clock and time base
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned TICK_NS       = 1000000;
  localparam int unsigned TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_PCFG0    = 8'h04;
  localparam logic [7:0] OFS_PTIME0   = 8'h08;
  localparam logic [7:0] OFS_PCFG1    = 8'h0c;
  localparam logic [7:0] OFS_PTIME1   = 8'h10;
  localparam logic [7:0] OFS_DIRTHR   = 8'h14;
  localparam logic [7:0] OFS_TIPDIA   = 8'h18;
  localparam logic [7:0] OFS_STATE    = 8'h1c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
  localparam logic [7:0] OFS_HITPOS0  = 8'h28;
  localparam logic [7:0] OFS_HITPOS1  = 8'h2c;
  localparam logic [7:0] OFS_TRUEPOS  = 8'h30;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_ACTIVE_BIT = 0;
  localparam int unsigned CTRL_DUAL_BIT   = 1;
  localparam int unsigned IRQ_HIT0_BIT    = 0;
  localparam int unsigned IRQ_HIT1_BIT    = 1;
  localparam int unsigned IRQ_REV_BIT     = 2;
  localparam int unsigned IRQ_W           = 3;
  localparam logic [1:0]  CTRL_RST        = 2'h0;
  localparam logic [15:0] DIRTHR_RST      = 16'h0028;
  localparam logic [15:0] TIPDIA_RST      = 16'h0000;

  // Edge sense codes
  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Per-probe qualifier settings
  typedef struct packed {
    logic [1:0]  edge_sel;
    logic [15:0] debounce_ms;
    logic [15:0] holdoff_ms;
  } peq_cfg_t;

  localparam peq_cfg_t CFG_RST = '{edge_sel: EDGE_OFF, debounce_ms: 16'h0000, holdoff_ms: 16'h0000};

  // Confirmed direction of motion
  typedef enum logic [1:0] {DIR_NONE, DIR_POS, DIR_NEG} peq_dir_t;

endpackage

// ===== src/peq_chan.sv
// One probe input: debounce, edge selection and hold-off
`timescale 1ns/1ns
module peq_chan
  import peq_pkg::*;
(
  input  wire logic     pclk,
  input  wire logic     presetn,
  input  wire logic     ms_tick,
  input  wire peq_cfg_t cfg,
  input  wire logic     probe_raw,
  output logic          hit,
  output logic          level
);

  typedef enum logic [1:0] {Q_STABLE, Q_SETTLE} peq_qstate_t;

  peq_qstate_t qstate;
  logic [15:0] settle_cnt;
  logic [15:0] hold_cnt;
  logic        hold_act;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Settling done once the programmed milliseconds have passed
  wire settled   = settle_cnt >= cfg.debounce_ms;
  wire accept    = qstate == Q_SETTLE && probe_raw != level && settled;
  wire is_rise   = ~level;
  wire edge_ok   = (cfg.edge_sel == EDGE_BOTH) ||
                   (cfg.edge_sel == EDGE_RISE && is_rise) ||
                   (cfg.edge_sel == EDGE_FALL && !is_rise);
  // edge sense gate; disabled gives no hit; hold-off blocks
  wire next_hit  = accept && edge_ok && !hold_act;
  wire hold_done = hold_cnt >= cfg.holdoff_ms;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qstate     <= Q_STABLE;
      settle_cnt <= 16'h0000;
      level      <= 1'b0;
    end else begin
      unique case (qstate)
        Q_STABLE: begin
          settle_cnt <= 16'h0000;
          if (probe_raw != level) begin
            qstate <= Q_SETTLE;
          end
        end
        Q_SETTLE: begin
          if (probe_raw == level) begin
            qstate     <= Q_STABLE;
            settle_cnt <= 16'h0000;
          end else if (settled) begin
            qstate <= Q_STABLE;
            level  <= probe_raw;
          end else if (ms_tick) begin
            settle_cnt <= settle_cnt + 16'h0001;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_act <= 1'b0;
      hold_cnt <= 16'h0000;
    end else if (next_hit) begin
      hold_act <= 1'b1;
      hold_cnt <= 16'h0000;
    end else if (hold_act && hold_done) begin
      hold_act <= 1'b0;
    end else if (hold_act && ms_tick) begin
      hold_cnt <= hold_cnt + 16'h0001;
    end
  end

  // One-cycle hit pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hit <= 1'b0;
    end else begin
      hit <= next_hit;
    end
  end

endmodule

// ===== test/peq_checker.sv
// Port checker for the probe edge qualifier, bound to the top module
`timescale 1ns/1ns
module peq_checker
  import peq_pkg::*;
#(
  parameter int unsigned MS_CYCLES = TICK_CYCLES
)
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [1:0]  probe_in,
  input wire logic [31:0] enc_count,
  input wire logic [1:0]  hit_pulse,
  input wire logic        dir_valid,
  input wire logic        dir_pos,
  input wire logic [31:0] true_pos
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // Recent encoder motion
  // ----------------------------------------------------------------
  logic [31:0] enc_q;
  logic [3:0]  moved;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enc_q <= 32'h0;
      moved <= 4'h0;
    end else begin
      enc_q <= enc_count;
      moved <= {moved[2:0], enc_count != enc_q};
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  chk_ready_setup: assert property (s_setup |=> s_answer)
    else $error("pready not one cycle after setup");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside access");
  chk_hit_once: assert property (hit_pulse != 2'h0 |=> (hit_pulse & $past(hit_pulse)) == 2'h0)
    else $error("hit pulse longer than one cycle");
  chk_hit_settled: assert property (hit_pulse[0] |-> $past(probe_in[0], 1) == $past(probe_in[0], 2))
    else $error("hit without settled input");
  chk_dir_sign: assert property (dir_pos |-> dir_valid)
    else $error("positive direction without valid");
  chk_dir_kept: assert property (dir_valid |=> dir_valid)
    else $error("confirmed direction lost");
  chk_dir_cause: assert property (($rose(dir_valid) || $changed(dir_pos)) |-> moved != 4'h0)
    else $error("direction changed without motion");
  chk_comp_none: assert property (!dir_valid |-> true_pos == enc_q)
    else $error("offset applied with no direction");
  chk_comp_side: assert property (dir_valid |-> (dir_pos ? true_pos - enc_q : enc_q - true_pos) <= 32'h7fff)
    else $error("compensation on the trailing side");
endmodule

bind peq_top peq_checker #(.MS_CYCLES(MS_CYCLES)) i_peq_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .probe_in(probe_in), .enc_count(enc_count),
  .hit_pulse(hit_pulse), .dir_valid(dir_valid), .dir_pos(dir_pos), .true_pos(true_pos));

// ===== test/peq_probe_sim.sv
// Touch-probe switch and axis encoder model
`timescale 1ns/1ns
module peq_probe_sim (
  input  wire logic   pclk,
  output logic [1:0]  probe_in,
  output logic [31:0] enc_count
);
  initial begin
    probe_in = 2'h0;
    enc_count = 32'h0;
  end

  // Contact with one short bounce before the level holds
  task automatic press(input int ch, input logic lvl);
    @(posedge pclk) probe_in[ch] <= lvl;
    @(posedge pclk) probe_in[ch] <= !lvl;
    @(posedge pclk) probe_in[ch] <= lvl;
  endtask

  // Encoder steps once each cycle
  task automatic move(input logic [31:0] step, input int n);
    repeat (n) @(posedge pclk) enc_count <= enc_count + step;
  endtask
endmodule

// ===== test/peq_top_test.sv
// Self-checking bench for the probe edge qualifier
`timescale 1ns/1ns
module peq_top_test
  import peq_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  probe_in;
  logic [31:0] enc_count;
  logic [1:0]  hit_pulse;
  logic        dir_valid;
  logic        dir_pos;
  logic [31:0] true_pos;
  logic        irq;
  logic [31:0] r;
  logic        e;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          hits [2] = '{0, 0};
  int          base;
  int          pos;
  logic [7:0]  ra [9] = '{OFS_CTRL, OFS_PCFG0, OFS_PTIME0, OFS_DIRTHR, OFS_TIPDIA, OFS_STATE,
                          OFS_IRQ_STAT, OFS_IRQ_MASK, OFS_TRUEPOS};
  logic [31:0] rv [9] = '{32'h0, 32'h0, 32'h0, 32'(DIRTHR_RST), 32'(TIPDIA_RST), 32'h0, 32'h0, 32'h0, 32'h0};

  peq_top #(.MS_CYCLES(4)) i_peq_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .probe_in(probe_in), .enc_count(enc_count), .hit_pulse(hit_pulse), .dir_valid(dir_valid),
    .dir_pos(dir_pos), .true_pos(true_pos), .irq(irq));
  peq_probe_sim i_peq_probe_sim (.pclk(pclk), .probe_in(probe_in), .enc_count(enc_count));

  // ----------------------------------------------------------------
  // Clock, hit monitor, bus tasks
  // ----------------------------------------------------------------
  always #25 pclk = ~pclk;

  // Count accepted hits per input
  always @(posedge pclk) begin
    for (int i = 0; i < 2; i++) if (hit_pulse[i] === 1'b1) hits[i]++;
  end

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    samples_checked++;
    if (got !== ex) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // One APB transfer: setup, then access until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd_data, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    chk("pready seen", 1'b1, pready);
    rd_data = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, ex, r);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    wait_cyc(2);
    presetn <= 1'b1;
    for (int i = 0; i < 9; i++) rd(ra[i], rv[i], "reset value");
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk("unmapped error", 1'b1, e);
    chk("unmapped data", 32'h0, r);
    wr(OFS_STATE, 32'hf);
    rd(OFS_STATE, 32'h0, "read-only state");
    $display("test registers done");
    wr(OFS_CTRL, 32'h2);
    for (int ch = 0; ch < 2; ch++) begin
      for (int es = 0; es < 4; es++) begin
        wr(ch ? OFS_PCFG1 : OFS_PCFG0, es);
        wr(ch ? OFS_PTIME1 : OFS_PTIME0, 32'h0000_0002);
        base = hits[ch];
        i_peq_probe_sim.press(ch, 1'b1);
        wait_cyc(30);
        i_peq_probe_sim.press(ch, 1'b0);
        wait_cyc(30);
        chk("edge hits", (es == 1) + (es == 2) + 2 * (es == 3), hits[ch] - base);
      end
    end
    wr(OFS_CTRL, 32'h0);
    base = hits[1];
    i_peq_probe_sim.press(1, 1'b1);
    wait_cyc(30);
    chk("single mode hits", 0, hits[1] - base);
    i_peq_probe_sim.press(1, 1'b0);
    wait_cyc(30);
    $display("test edges done");
    rd(OFS_IRQ_STAT, 32'h3, "hit status");
    chk("irq masked", 1'b0, irq);
    wr(OFS_IRQ_MASK, 32'h1);
    wait_cyc(3);
    chk("irq raised", 1'b1, irq);
    wr(OFS_IRQ_STAT, 32'h1);
    wait_cyc(3);
    chk("irq cleared", 1'b0, irq);
    rd(OFS_IRQ_STAT, 32'h2, "status after clear");
    wr(OFS_IRQ_STAT, 32'h7);
    $display("test interrupt done");
    wr(OFS_PTIME0, 32'h000a_0002);
    base = hits[0];
    i_peq_probe_sim.press(0, 1'b1);
    wait_cyc(17);
    i_peq_probe_sim.press(0, 1'b0);
    wait_cyc(60);
    chk("hits in hold-off", 1, hits[0] - base);
    i_peq_probe_sim.press(0, 1'b1);
    wait_cyc(30);
    chk("hits after hold-off", 2, hits[0] - base);
    $display("test hold-off done");
    wr(OFS_IRQ_STAT, 32'h7);
    wr(OFS_DIRTHR, 32'd40);
    wr(OFS_TIPDIA, 32'd10);
    wr(OFS_CTRL, 32'h1);
    i_peq_probe_sim.move(32'h1, 45);
    pos = 45;
    wait_cyc(3);
    rd(OFS_STATE, 32'h7, "first direction");
    chk("true pos up", 32'(pos + 5), true_pos);
    rd(OFS_IRQ_STAT, 32'h0, "no reversal flag");
    i_peq_probe_sim.move(32'hffff_ffff, 39);
    i_peq_probe_sim.move(32'h1, 1);
    i_peq_probe_sim.move(32'hffff_ffff, 39);
    pos = pos - 77;
    wait_cyc(3);
    chk("direction held", 1'b1, dir_pos);
    i_peq_probe_sim.move(32'hffff_ffff, 1);
    pos = pos - 1;
    wait_cyc(3);
    chk("direction valid", 1'b1, dir_valid);
    chk("direction reversed", 1'b0, dir_pos);
    chk("true pos down", 32'(pos - 5), true_pos);
    rd(OFS_IRQ_STAT, 32'h4, "reversal flag");
    i_peq_probe_sim.press(0, 1'b0);
    wait_cyc(30);
    rd(OFS_HITPOS0, 32'(pos - 5), "hit position");
    $display("test direction done");
    finish_test();
  end

  // Watchdog well beyond the expected run
  initial begin
    #(20000 * 50);
    error_cnt++;
    $display("FAIL watchdog expected end seen timeout");
    finish_test();
  end
endmodule
